// ---- design/nvm_buffer_segment_sequencer.sv ----
// nvm list sequencer: control registers and command list walker

// Overview of operation
// - command list gives start addresses and counts
// - command bit 7 clear means data transfer
// - low seven bits hold byte count minus one
// - two following bytes give address, high first
// - command bit 7 set means controller opcode
// - commit opcode pulses the update-all strobe
// - end-of-data opcode stops the walk
// - default list moves everything, then commits
// - busy flag high while save or load runs
// - status pin shows busy when selected
// - update-all bit pulses next edge, self-clears
// - save bit starts save, clears at end
// - write enable low refuses memory writes
module nvm_buffer_segment_sequencer (
  // clock, reset, enable
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  // serial control port register access
  input  wire logic [nvm_seq_pkg::REG_AW-1:0] reg_addr,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [nvm_seq_pkg::DW-1:0]     reg_wdata,
  output logic      [nvm_seq_pkg::DW-1:0]     reg_rdata,
  // load request from the reset path
  input  wire logic                           load_start,
  // register map side
  output logic      [nvm_seq_pkg::MAP_AW-1:0] map_addr,
  output logic                                map_rd,
  output logic                                map_wr,
  output logic      [nvm_seq_pkg::DW-1:0]     map_wdata,
  input  wire logic [nvm_seq_pkg::DW-1:0]     map_rdata,
  // nonvolatile memory side
  output logic      [nvm_seq_pkg::NVM_AW-1:0] nvm_addr,
  output logic                                nvm_rd,
  output logic                                nvm_wr,
  output logic      [nvm_seq_pkg::DW-1:0]     nvm_wdata,
  input  wire logic [nvm_seq_pkg::DW-1:0]     nvm_rdata,
  input  wire logic                           nvm_done,
  // commit strobe and status
  output logic                                update_all,
  output logic                                xfer_busy,
  output logic                                status_pin
);
  import nvm_seq_pkg::*;

  // ==================================================================
  // declarations
  walk_state_t         state_r;      // walker state
  logic                dir_save_r;   // 1 save to memory, 0 load
  logic [LIST_IW-1:0]  idx_r;        // current list byte
  logic [6:0]          cnt_r;        // bytes left minus one
  logic [MAP_AW-1:0]   addr_r;       // register map pointer
  logic [NVM_AW-1:0]   nptr_r;       // memory byte pointer
  logic                busy_r;       // transfer in progress
  logic                wren_r;       // memory write enable
  logic                statsel_r;    // status pin shows busy
  logic                save_r;       // save bit, reads back
  logic                upd_r;        // update-all strobe
  logic                status_r;     // status pin flop
  logic [DW-1:0]       rdata_r;      // read data flop
  logic [MAP_AW-1:0]   map_addr_r;
  logic                map_rd_r;
  logic                map_wr_r;
  logic [DW-1:0]       map_wdata_r;
  logic [NVM_AW-1:0]   nvm_addr_r;
  logic                nvm_rd_r;
  logic                nvm_wr_r;
  logic [DW-1:0]       nvm_wdata_r;
  logic                op_commit;    // walker hit a commit opcode
  logic                wr_hit_save;  // accepted save request
  logic                go_save;      // start a save this cycle
  logic                go_load;      // start a load this cycle
  logic [DW-1:0]       list_a;       // list byte for software
  logic [DW-1:0]       list_b;       // list byte for the walker
  logic [DW-1:0]       rd_mux;       // decoded read value
  logic                list_wr;      // software writes the list

  // ==================================================================
  // address decode, shared by the read and write paths
  function automatic logic in_list(input logic [REG_AW-1:0] a);
    in_list = (a >= LIST_FIRST) && (a <= LIST_LAST);
  endfunction

  assign list_wr = reg_wr && in_list(reg_addr);

  // ==================================================================
  // command list storage
  cmd_list_store u_store (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_en     (list_wr),
    .wr_idx    (reg_addr[LIST_IW-1:0]),
    .wr_data   (reg_wdata),
    .rd_idx_a  (reg_addr[LIST_IW-1:0]),
    .rd_data_a (list_a),
    .rd_idx_b  (idx_r),
    .rd_data_b (list_b)
  );

  // ==================================================================
  // start decisions; a save needs the write enable and an idle walker
  assign wr_hit_save = reg_wr && (reg_addr == SAVE_OFS) &&
                       reg_wdata[SAVE_BIT] && wren_r;
  assign go_save = wr_hit_save && !busy_r;
  // save wins when both arrive together; the load is dropped
  assign go_load = load_start && !busy_r && !wr_hit_save;
  assign op_commit = (state_r == st_cmd) && list_b[OPCODE_BIT] &&
                     (list_b == OP_COMMIT);

  // ==================================================================
  // software control bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wren_r    <= WREN_RST;
      statsel_r <= STATSEL_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == WREN_OFS) begin
        wren_r <= reg_wdata[WREN_BIT];
      end else if (reg_addr == STATSEL_OFS) begin
        statsel_r <= reg_wdata[STATSEL_BIT];
      end
    end
  end

  // ==================================================================
  // save bit: set by an accepted request, cleared by the walker end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      save_r <= 1'b0;
    end else if (ce) begin
      if (go_save) begin
        save_r <= 1'b1;
      end else if (state_r == st_done) begin
        save_r <= 1'b0;
      end
    end
  end

  // ==================================================================
  // update-all strobe: one cycle, from software or the commit opcode;
  // the read path does not decode UPDATE_OFS, so it reads back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upd_r <= 1'b0;
    end else if (ce) begin
      upd_r <= (reg_wr && (reg_addr == UPDATE_OFS) &&
                reg_wdata[UPDATE_BIT])
               || op_commit;
    end
  end

  // ==================================================================
  // busy flag and the status pin that mirrors it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r   <= 1'b0;
      status_r <= 1'b0;
    end else if (ce) begin
      if (go_save || go_load) begin
        busy_r <= 1'b1;
      end else if (state_r == st_done) begin
        busy_r <= 1'b0;
      end
      // lags the flag by one cycle; keeps the pin glitch free
      status_r <= statsel_r && busy_r;
    end
  end

  // ==================================================================
  // register read path; data stands from the edge after reg_rd
  always_comb begin
    rd_mux = RDATA_RST;
    if (in_list(reg_addr)) begin
      rd_mux = list_a;
    end else if (reg_addr == BUSY_OFS) begin
      rd_mux[BUSY_BIT] = busy_r;
    end else if (reg_addr == WREN_OFS) begin
      rd_mux[WREN_BIT] = wren_r;
    end else if (reg_addr == SAVE_OFS) begin
      rd_mux[SAVE_BIT] = save_r;
    end else if (reg_addr == STATSEL_OFS) begin
      rd_mux[STATSEL_BIT] = statsel_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= RDATA_RST;
    end else if (ce && reg_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // ==================================================================
  // list walker: parses entries and moves bytes one at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= st_idle;
      dir_save_r  <= 1'b0;
      idx_r       <= '0;
      cnt_r       <= '0;
      addr_r      <= '0;
      nptr_r      <= '0;
      map_addr_r  <= '0;
      map_rd_r    <= 1'b0;
      map_wr_r    <= 1'b0;
      map_wdata_r <= '0;
      nvm_addr_r  <= '0;
      nvm_rd_r    <= 1'b0;
      nvm_wr_r    <= 1'b0;
      nvm_wdata_r <= '0;
    end else if (ce) begin
      // strobes last one cycle unless set again below
      map_rd_r <= 1'b0;
      map_wr_r <= 1'b0;
      nvm_rd_r <= 1'b0;
      nvm_wr_r <= 1'b0;
      case (state_r)
        st_idle: begin
          if (go_save || go_load) begin
            dir_save_r <= go_save;
            idx_r      <= '0;
            nptr_r     <= '0;
            state_r    <= st_cmd;
          end
        end
        st_cmd: begin
          if (!list_b[OPCODE_BIT]) begin
            cnt_r   <= list_b[6:0];
            idx_r   <= idx_r + 1'b1;
            // a transfer in the last byte has no address: stop
            state_r <= (idx_r == LIST_LAST[LIST_IW-1:0]) ?
                       st_done : st_addr_hi;
          end else if (list_b == OP_END ||
                       idx_r == LIST_LAST[LIST_IW-1:0]) begin
            state_r <= st_done;
          end else begin
            // commit is strobed from op_commit; unknown codes skip
            idx_r <= idx_r + 1'b1;
          end
        end
        st_addr_hi: begin
          addr_r[15:8] <= list_b;
          idx_r        <= idx_r + 1'b1;
          state_r      <= st_addr_lo;
        end
        st_addr_lo: begin
          addr_r[7:0] <= list_b;
          idx_r       <= idx_r + 1'b1;
          state_r     <= st_src;
        end
        st_src: begin
          if (dir_save_r) begin
            map_addr_r <= addr_r;
            map_rd_r   <= 1'b1;
            state_r    <= st_get;
          end else begin
            nvm_addr_r <= nptr_r;
            nvm_rd_r   <= 1'b1;
            state_r    <= st_wait;
          end
        end
        st_get: begin
          // register map answers in the cycle after map_rd
          state_r <= st_snk;
        end
        st_snk: begin
          nvm_addr_r  <= nptr_r;
          nvm_wdata_r <= map_rdata;
          nvm_wr_r    <= wren_r;
          state_r     <= st_wait;
        end
        st_wait: begin
          if (nvm_done) begin
            if (!dir_save_r) begin
              map_addr_r  <= addr_r;
              map_wdata_r <= nvm_rdata;
              map_wr_r    <= 1'b1;
            end
            addr_r <= addr_r + 1'b1;
            nptr_r <= nptr_r + 1'b1;
            if (cnt_r == 7'h00) begin
              state_r <= st_cmd;
            end else begin
              cnt_r   <= cnt_r - 1'b1;
              state_r <= st_src;
            end
          end
        end
        st_done: begin
          state_r <= st_idle;
        end
        default: begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  // ==================================================================
  // outputs, each straight from a flop
  assign reg_rdata  = rdata_r;
  assign map_addr   = map_addr_r;
  assign map_rd     = map_rd_r;
  assign map_wr     = map_wr_r;
  assign map_wdata  = map_wdata_r;
  assign nvm_addr   = nvm_addr_r;
  assign nvm_rd     = nvm_rd_r;
  assign nvm_wr     = nvm_wr_r;
  assign nvm_wdata  = nvm_wdata_r;
  assign update_all = upd_r;
  assign xfer_busy  = busy_r;
  assign status_pin = status_r;

endmodule

// ---- design/nvm_seq_pkg.sv ----
// constants, types and default command list of the nvm list sequencer
package nvm_seq_pkg;

  // ==================================================================
  // widths and depths
  localparam int REG_AW  = 12;   // serial control port address width
  localparam int DW      = 8;    // every register is one byte
  localparam int MAP_AW  = 16;   // register map address from the list
  localparam int NVM_AW  = 10;   // byte address into the memory array
  localparam int LIST_IW = 8;    // index into the command list
  localparam int LIST_N  = 256;  // command list depth in bytes

  // ==================================================================
  // register offsets
  localparam logic [REG_AW-1:0] LIST_FIRST  = 12'hA00;
  localparam logic [REG_AW-1:0] LIST_LAST   = 12'hAFF;
  localparam logic [REG_AW-1:0] BUSY_OFS    = 12'hB00;
  localparam logic [REG_AW-1:0] SPARE_OFS   = 12'hB01;
  localparam logic [REG_AW-1:0] WREN_OFS    = 12'hB02;
  localparam logic [REG_AW-1:0] SAVE_OFS    = 12'hB03;
  localparam logic [REG_AW-1:0] UPDATE_OFS  = 12'h232;
  localparam logic [REG_AW-1:0] STATSEL_OFS = 12'h01D;

  // ==================================================================
  // field positions and reset values
  localparam int BUSY_BIT    = 0;
  localparam int WREN_BIT    = 0;
  localparam int SAVE_BIT    = 0;
  localparam int UPDATE_BIT  = 0;
  localparam int STATSEL_BIT = 7;
  localparam int OPCODE_BIT  = 7;  // set marks a controller opcode
  localparam logic WREN_RST    = 1'b0;  // memory writes locked
  localparam logic STATSEL_RST = 1'b0;
  localparam logic [DW-1:0] RDATA_RST = 8'h00;

  // ==================================================================
  // opcodes
  localparam logic [DW-1:0] OP_COMMIT = 8'h80;
  localparam logic [DW-1:0] OP_END    = 8'hFF;

  // ==================================================================
  // sequencer states
  typedef enum logic [3:0] {
    st_idle, st_cmd, st_addr_hi, st_addr_lo, st_src, st_get,
    st_snk, st_wait, st_done
  } walk_state_t;

  // default list: whole map in four 128-byte runs, the system bytes,
  // then commit and end of data; the tail is filled with end codes
  function automatic logic [DW-1:0] default_cmd(
    input logic [LIST_IW-1:0] idx);
    case (idx)
      8'h00, 8'h03, 8'h06, 8'h09: default_cmd = 8'h7F;
      8'h01, 8'h02, 8'h04:        default_cmd = 8'h00;
      8'h05, 8'h0B, 8'h0F:        default_cmd = 8'h80;
      8'h07, 8'h0A, 8'h0C:        default_cmd = 8'h01;
      8'h08:                      default_cmd = 8'h00;
      8'h0D:                      default_cmd = 8'h02;
      8'h0E:                      default_cmd = 8'h30;
      default:                    default_cmd = OP_END;
    endcase
  endfunction

endpackage

// ---- design/cmd_list_store.sv ----
// command list storage: 256 bytes of flops with two read indices
module cmd_list_store
  import nvm_seq_pkg::*;
(
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // software write port
  input  wire logic               wr_en,
  input  wire logic [LIST_IW-1:0] wr_idx,
  input  wire logic [DW-1:0]      wr_data,
  // software read port
  input  wire logic [LIST_IW-1:0] rd_idx_a,
  output logic      [DW-1:0]      rd_data_a,
  // sequencer read port
  input  wire logic [LIST_IW-1:0] rd_idx_b,
  output logic      [DW-1:0]      rd_data_b
);

  logic [DW-1:0] mem_r [LIST_N];  // list bytes

  // ==================================================================
  // storage; reset reloads the default list so a blank part still
  // moves every register each way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LIST_N; i++) begin
        mem_r[i] <= default_cmd(LIST_IW'(i));
      end
    end else if (ce && wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  // ==================================================================
  // reads are combinational; both callers register what they take
  assign rd_data_a = mem_r[rd_idx_a];
  assign rd_data_b = mem_r[rd_idx_b];

endmodule

// ---- testbench/nvm_seq_asserts.sv ----
// port-level checks on the nvm list sequencer
module nvm_seq_asserts
  import nvm_seq_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              ce,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DW-1:0]     reg_wdata,
  input wire logic [DW-1:0]     reg_rdata,
  input wire logic              load_start,
  // strobes and status
  input wire logic              map_rd,
  input wire logic              map_wr,
  input wire logic              nvm_rd,
  input wire logic              nvm_wr,
  input wire logic              update_all,
  input wire logic              xfer_busy,
  input wire logic              status_pin
);
  // ================================================
  // shadows of the control bits
  logic wren_h;  // memory write enable copy
  logic sel_h;   // status select copy
  // follow software writes so checks need no internal probes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wren_h <= WREN_RST;
      sel_h  <= STATSEL_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == WREN_OFS) wren_h <= reg_wdata[WREN_BIT];
      if (reg_addr == STATSEL_OFS) sel_h <= reg_wdata[STATSEL_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ================================================
  // save request while idle
  sequence s_save_req;
    ce && reg_wr && reg_addr == SAVE_OFS && reg_wdata[SAVE_BIT]
      && !xfer_busy;
  endsequence
  a_save_locked: assert property (
    s_save_req ##0 (!wren_h && !load_start) |=> !xfer_busy)
    else $error("save started while locked");
  a_save_starts: assert property (
    s_save_req ##0 wren_h |=> xfer_busy)
    else $error("save did not start");
  a_load_starts: assert property (
    ce && load_start && !xfer_busy
    && !(reg_wr && reg_addr == SAVE_OFS) |=> xfer_busy)
    else $error("load did not start");
  a_commit_strobe: assert property (
    ce && reg_wr && reg_addr == UPDATE_OFS
    && reg_wdata[UPDATE_BIT] |=> update_all)
    else $error("commit strobe missing");
  a_commit_single: assert property (
    update_all |=> !update_all)
    else $error("commit strobe too long");
  a_status_mirror: assert property (
    status_pin == ($past(sel_h) && $past(xfer_busy)))
    else $error("status pin wrong");
  a_busy_read: assert property (
    ce && reg_rd && reg_addr == BUSY_OFS
    |=> reg_rdata == {7'h00, $past(xfer_busy)})
    else $error("busy readback wrong");
  a_save_clears: assert property (
    ce && reg_rd && reg_addr == SAVE_OFS
    && !xfer_busy |=> reg_rdata == 8'h00)
    else $error("save bit stuck");
  a_locked_no_write: assert property (
    nvm_wr |-> $past(wren_h))
    else $error("memory written while locked");
  a_idle_quiet: assert property (
    !xfer_busy |-> !(map_rd || map_wr || nvm_rd || nvm_wr))
    else $error("strobe while idle");
endmodule
bind nvm_buffer_segment_sequencer nvm_seq_asserts chk_u (.clk, .rst, .ce,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .load_start,
  .map_rd, .map_wr, .nvm_rd, .nvm_wr, .update_all, .xfer_busy,
  .status_pin);

// ---- testbench/nvm_partner_model.sv ----
// partner model: register map image and nonvolatile array
module nvm_partner_model
  import nvm_seq_pkg::*;
(
  // clock and pacing
  input  wire logic              clk,
  input  wire logic              slow,
  // register map side
  input  wire logic [MAP_AW-1:0] map_addr,
  input  wire logic              map_rd,
  input  wire logic              map_wr,
  input  wire logic [DW-1:0]     map_wdata,
  output logic      [DW-1:0]     map_rdata,
  // memory side
  input  wire logic [NVM_AW-1:0] nvm_addr,
  input  wire logic              nvm_rd,
  input  wire logic              nvm_wr,
  input  wire logic [DW-1:0]     nvm_wdata,
  output logic      [DW-1:0]     nvm_rdata,
  output logic                   nvm_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DW-1:0]     map_mem [0:65535];  // register map image
  logic [DW-1:0]     nvm_mem [0:1023];   // nonvolatile array
  logic              pend;               // access in flight
  logic [NVM_AW-1:0] pa;                 // address of that access
  int                wait_n;             // extra cycles before done
  initial begin
    map_rdata = 8'h00;
    nvm_rdata = 8'h00;
    nvm_done = 1'b0;
    pend = 1'b0;
  end
  // ================================================
  // map answers next cycle; between reads the bus wanders
  always @(posedge clk) begin
    if (map_wr) map_mem[map_addr] <= map_wdata;
    map_rdata <= map_rd ? map_mem[map_addr] : ~map_rdata;
  end
  // ================================================
  // memory: done two or five cycles after each strobe
  always @(posedge clk) begin
    nvm_done <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (nvm_rd || nvm_wr) begin
      if (nvm_wr) nvm_mem[nvm_addr] <= nvm_wdata;
      pa <= nvm_addr;
      pend <= 1'b1;
      wait_n <= slow ? 3 : 0;
    end else if (pend && wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (pend) begin
      pend <= 1'b0;
      nvm_done <= 1'b1;
      nvm_rdata <= nvm_mem[pa];
    end
  end
endmodule

// ---- testbench/tb_nvm_buffer_segment_sequencer.sv ----
// self-checking bench for the nvm list sequencer
module tb_nvm_buffer_segment_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import nvm_seq_pkg::*;
  logic              clk, rst, ce, reg_wr, reg_rd, load_start, slow;
  logic [REG_AW-1:0] reg_addr;
  logic [DW-1:0]     reg_wdata, reg_rdata, map_wdata, map_rdata;
  logic [DW-1:0]     nvm_wdata, nvm_rdata;
  logic [MAP_AW-1:0] map_addr;
  logic [NVM_AW-1:0] nvm_addr;
  logic              map_rd, map_wr, nvm_rd, nvm_wr, nvm_done;
  logic              update_all, xfer_busy, status_pin;
  int                miscompares, compares, ucnt, mwcnt, spcnt;
  nvm_buffer_segment_sequencer dut_u (.clk, .rst, .ce, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .load_start, .map_addr, .map_rd,
    .map_wr, .map_wdata, .map_rdata, .nvm_addr, .nvm_rd, .nvm_wr,
    .nvm_wdata, .nvm_rdata, .nvm_done, .update_all, .xfer_busy,
    .status_pin);
  nvm_partner_model p_u (.clk, .slow, .map_addr, .map_rd, .map_wr,
    .map_wdata, .map_rdata, .nvm_addr, .nvm_rd, .nvm_wr, .nvm_wdata,
    .nvm_rdata, .nvm_done);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count strobes and status cycles
  always @(posedge clk) begin
    if (update_all === 1'b1) ucnt++;
    if (map_wr === 1'b1) mwcnt++;
    if (status_pin === 1'b1) spcnt++;
  end
  // ================================================
  // tasks
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask
  // list bytes from the first entry upward
  task automatic prog(logic [7:0] q[$]);
    foreach (q[i]) wr(LIST_FIRST + 12'(i), q[i]);
  endtask
  task automatic pulse_load();
    @(negedge clk);
    load_start = 1'b1;
    @(negedge clk);
    load_start = 1'b0;
  endtask
  // see busy rise, wait for it to fall, then keep the idle gap
  task automatic run(int lim);
    int n;
    n = 0;
    while (xfer_busy !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk("busy rise", 16'h1, {15'h0, xfer_busy});
    n = 0;
    while (xfer_busy !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("busy fall", 16'h0, {15'h0, xfer_busy});
    repeat (1000) @(negedge clk);
  endtask
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    // the whole sequence needs under 10,000 cycles; allow three times
    #300000;
    miscompares++;
    close_out();
  end
  // ================================================
  // main sequence
  initial begin
    {rst, ce, reg_wr, reg_rd, load_start, slow} = 6'b110000;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rd(BUSY_OFS, 8'h00);
    rd(SPARE_OFS, 8'h00);
    rd(12'h7FF, 8'h00);
    rd(LIST_FIRST, 8'h7F);
    rd(LIST_LAST, OP_END);
    ucnt = 0;
    wr(UPDATE_OFS, 8'h01);
    @(negedge clk);
    chk("update count", 16'h1, 16'(ucnt));
    rd(UPDATE_OFS, 8'h00);
    // a low clock enable must drop the write
    ce = 1'b0;
    wr(STATSEL_OFS, 8'h80);
    ce = 1'b1;
    rd(STATSEL_OFS, 8'h00);
    wr(SAVE_OFS, 8'h01);
    repeat (5) @(negedge clk);
    chk("locked busy", 16'h0, {15'h0, xfer_busy});
    rd(SAVE_OFS, 8'h00);
    // two-byte save then commit
    prog('{8'h01, 8'h00, 8'h10, OP_COMMIT, OP_END});
    p_u.map_mem[16'h0010] = 8'hA5;
    p_u.map_mem[16'h0011] = 8'h3C;
    wr(STATSEL_OFS, 8'h80);
    wr(WREN_OFS, 8'h01);
    ucnt = 0;
    wr(SAVE_OFS, 8'h01);
    rd(BUSY_OFS, 8'h01);
    chk("status pin", 16'h1, {15'h0, status_pin});
    rd(SAVE_OFS, 8'h01);
    run(200);
    chk("nvm 0", 16'h00A5, {8'h00, p_u.nvm_mem[0]});
    chk("nvm 1", 16'h003C, {8'h00, p_u.nvm_mem[1]});
    chk("commit count", 16'h1, 16'(ucnt));
    rd(SAVE_OFS, 8'h00);
    // slow load, unknown opcode between entries, status unselected
    prog('{8'h00, 8'h00, 8'h20, 8'h81, 8'h00, 8'h00, 8'h21, OP_END});
    wr(STATSEL_OFS, 8'h00);
    slow = 1'b1;
    ucnt = 0;
    mwcnt = 0;
    spcnt = 0;
    pulse_load();
    run(400);
    chk("map 20", 16'h00A5, {8'h00, p_u.map_mem[16'h0020]});
    chk("map 21", 16'h003C, {8'h00, p_u.map_mem[16'h0021]});
    chk("map writes", 16'h2, 16'(mwcnt));
    chk("no commit", 16'h0, 16'(ucnt));
    chk("status idle", 16'h0, 16'(spcnt));
    // end code first: nothing moves
    prog('{OP_END});
    mwcnt = 0;
    pulse_load();
    run(50);
    chk("end writes", 16'h0, 16'(mwcnt));
    // reset reloads the default list, which saves the whole map
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    slow = 1'b0;
    for (int i = 0; i < 16'h232; i++) p_u.map_mem[i] = 8'(i) ^ 8'h5A;
    rd(LIST_FIRST, 8'h7F);
    ucnt = 0;
    wr(WREN_OFS, 8'h01);
    wr(SAVE_OFS, 8'h01);
    run(20000);
    foreach (p_u.nvm_mem[k]) if (k < 16'h200) begin
      chk("default image", {8'h00, 8'(k) ^ 8'h5A},
          {8'h00, p_u.nvm_mem[k]});
    end
    chk("nvm 200", 16'h006A, {8'h00, p_u.nvm_mem[16'h200]});
    chk("nvm 201", 16'h006B, {8'h00, p_u.nvm_mem[16'h201]});
    chk("default commit", 16'h1, 16'(ucnt));
    close_out();
  end
endmodule
